// ### sef_pkg.sv
// sef_pkg: register offsets, field positions, reset values and timing for the serial port
// assumes: both ends import this package whole; the link interface does not import it
package sef_pkg;
  // ---------------------------------------------------------------
  // register map of the device end (byte addresses on the cpu port)
  // ---------------------------------------------------------------
  localparam logic [1:0] SEF_OFF_CTRL = 2'h0;  // control_reg
  localparam logic [1:0] SEF_OFF_CSR  = 2'h1;  // control_status_reg
  localparam logic [1:0] SEF_OFF_DATA = 2'h2;  // data_reg
  localparam logic [1:0] SEF_OFF_PWR  = 2'h3;  // power mode control
  // control_reg fields
  localparam int SEF_CR_IRQ_EN = 7;  // irq_enable_bit
  localparam int SEF_CR_PORT   = 6;  // port_enable_bit
  localparam int SEF_CR_CTRL   = 4;  // controller_select_bit
  // control_status_reg fields
  localparam int SEF_SR_DONE   = 7;  // transfer_done_flag
  localparam int SEF_SR_WRITE_COLLISION_FLAG   = 6;  // write_collision_flag
  localparam int SEF_SR_OVR    = 5;  // overrun_flag
  localparam int SEF_SR_MODE_FAULT_FLAG   = 4;  // mode_fault_flag
  localparam int SEF_SR_SSM    = 1;  // software select management
  localparam int SEF_SR_SSI    = 0;  // soft_select_level
  // power register fields
  localparam int SEF_PW_WAIT   = 0;
  localparam int SEF_PW_HALT   = 1;
  localparam logic [7:0] SEF_CR_RST  = 8'h00;
  localparam logic [7:0] SEF_CSR_RST = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SEF_CLK_NS    = 100;   // i_mclk period
  localparam int SEF_HALF_DIV  = 4;     // clocks per sclk half period of the host
  localparam int SEF_BITS      = 8;
endpackage

// ### sef_link_if.sv
// sef_link_if: the four wire serial link between the two ends
// assumes: one device end and one host end; the host treats miso as released while miso_oe is low
`timescale 1ns/100ps
interface sef_link_if;
  logic sclk;   // serial clock, made by the host
  logic mosi;   // host to device data
  logic miso;   // device to host data
  logic miso_oe;  // device drives miso while selected and enabled
  logic sel_n;  // slave select, active low, from host
  modport dev  (input sclk, input mosi, input sel_n, output miso, output miso_oe);
  modport host (output sclk, output mosi, output sel_n, input miso, input miso_oe);
endinterface

// ### sef_dev.sv
// sef_dev: device end of the serial port: flags, fault handling, wakeup
// assumes: cpu port strobes are one cycle, read data stands the cycle after a read;
//          link pins are asynchronous and are synchronised here
`timescale 1ns/100ps
module sef_dev
  import sef_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cpu_irq_mask,   // processor interrupt mask, high blocks
  output logic            o_irq,
  output logic            o_wake_wait,
  output logic            o_wake_halt,
  sef_link_if.dev         link
);
  // ---------------------------------------------------------------
  // synchronisers for the link pins
  // ---------------------------------------------------------------
  logic [2:0] sync1_r, sync2_r;
  logic       sclk_d_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // idle levels: clock low, data low, select high, so no false edge after reset
      sync1_r  <= 3'h1;
      sync2_r  <= 3'h1;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r  <= {link.sclk, link.mosi, link.sel_n};
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[2];
    end
  end
  wire s_sclk  = sync2_r[2];
  wire s_mosi  = sync2_r[1];
  wire pin_sel_n = sync2_r[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r, csr_r, shift_r, rxbuf_r, rdata_r;
  logic [3:0] bitcnt_r;
  logic       csr_seen_r;     // status access while done was set, or status read while fault or collision was set
  logic       wait_r, halt_r;
  logic       rx_lock_r;      // buffer holds unread byte after overrun

  wire irq_en  = ctrl_r[SEF_CR_IRQ_EN];
  wire port_en = ctrl_r[SEF_CR_PORT];
  wire is_ctrl = ctrl_r[SEF_CR_CTRL];
  wire f_done  = csr_r[SEF_SR_DONE];
  wire f_write_collision_flag  = csr_r[SEF_SR_WRITE_COLLISION_FLAG];
  wire f_ovr   = csr_r[SEF_SR_OVR];
  wire f_mode_fault_flag  = csr_r[SEF_SR_MODE_FAULT_FLAG];
  wire sel_n   = csr_r[SEF_SR_SSM] ? csr_r[SEF_SR_SSI] : pin_sel_n;

  // decode of cpu accesses; halt blocks nothing on the cpu port since cpu is stopped
  wire wr_ctrl = i_wr && (i_addr == SEF_OFF_CTRL);
  wire wr_csr  = i_wr && (i_addr == SEF_OFF_CSR);
  wire wr_data = i_wr && (i_addr == SEF_OFF_DATA);
  wire wr_pwr  = i_wr && (i_addr == SEF_OFF_PWR);
  wire rd_csr  = i_rd && (i_addr == SEF_OFF_CSR);
  wire rd_data = i_rd && (i_addr == SEF_OFF_DATA);
  wire acc_csr = rd_csr || wr_csr;

  // ---------------------------------------------------------------
  // link engine (slave shift only; a master side shift is outside this block)
  // ---------------------------------------------------------------
  wire active   = port_en && !is_ctrl && !sel_n && !halt_r;
  wire rise     = s_sclk && !sclk_d_r;
  wire fall     = !s_sclk && sclk_d_r;
  wire busy     = active && (bitcnt_r != 4'h0);
  // a data write loads only when it is not flagged as a collision; after a status
  // read a write is legal again even though done is still set
  wire wr_load  = wr_data && !busy && !f_mode_fault_flag && !(f_done && !csr_seen_r);
  // halt wakeup: slave selected at halt entry keeps sampling so done can wake it
  wire halt_rx  = halt_r && port_en && !is_ctrl && !sel_n;
  wire rx_on    = active || halt_rx;
  wire byte_done = rx_on && rise && (bitcnt_r == 4'(SEF_BITS - 1));
  wire [7:0] rx_byte = {shift_r[6:0], s_mosi};
  wire mode_fault_flag_evt = port_en && is_ctrl && !sel_n;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r  <= 8'h00;
      bitcnt_r <= 4'h0;
    end else if (!rx_on) begin
      bitcnt_r <= 4'h0;
      if (wr_load) shift_r <= i_wdata;  // load only when idle
    end else if (rise) begin
      shift_r  <= rx_byte;
      bitcnt_r <= (bitcnt_r == 4'(SEF_BITS - 1)) ? 4'h0 : bitcnt_r + 4'h1;
    end else if (wr_load) begin
      shift_r  <= i_wdata;
    end
  end

  // ---------------------------------------------------------------
  // clearing sequences: a qualifying status access arms the next step
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) csr_seen_r <= 1'b0;
    // fault and collision need a status read; done accepts any status access
    else if ((rd_csr && (f_mode_fault_flag || f_write_collision_flag)) || (acc_csr && f_done)) csr_seen_r <= 1'b1;
    else if (rd_data || wr_ctrl) csr_seen_r <= 1'b0;
  end

  // flag next values; every set beats a same-cycle clear
  wire done_nxt = byte_done ? 1'b1 :
                  ((csr_seen_r || acc_csr) && (rd_data || wr_data) ? 1'b0 : f_done);
  wire ovr_nxt  = (byte_done && f_done) ? 1'b1 : (rd_csr ? 1'b0 : f_ovr);
  wire mode_fault_flag_nxt = mode_fault_flag_evt ? 1'b1 : ((csr_seen_r && wr_ctrl) ? 1'b0 : f_mode_fault_flag);
  wire write_collision_flag_set = wr_data && (busy || (f_done && !csr_seen_r));
  wire write_collision_flag_nxt = write_collision_flag_set ? 1'b1 : ((csr_seen_r && rd_data) ? 1'b0 : f_write_collision_flag);

  // control write: fault blocks enable/master unless this write ends the fault
  wire mode_fault_flag_hold = f_mode_fault_flag && !csr_seen_r;
  wire [7:0] ctrl_w = mode_fault_flag_hold ?
                      (i_wdata & ~(8'h01 << SEF_CR_PORT) & ~(8'h01 << SEF_CR_CTRL)) :
                      i_wdata;
  wire [7:0] ctrl_nxt = mode_fault_flag_evt ?
                        (ctrl_r & ~(8'h01 << SEF_CR_PORT) & ~(8'h01 << SEF_CR_CTRL)) :
                        (wr_ctrl ? ctrl_w : ctrl_r);

  // ---------------------------------------------------------------
  // control, status and receive buffer; halt gates none of these updates
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r    <= SEF_CR_RST;
      csr_r     <= SEF_CSR_RST;
      rxbuf_r   <= 8'h00;
      rx_lock_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      csr_r[SEF_SR_DONE] <= done_nxt;
      csr_r[SEF_SR_OVR]  <= ovr_nxt;
      csr_r[SEF_SR_MODE_FAULT_FLAG] <= mode_fault_flag_nxt;
      csr_r[SEF_SR_WRITE_COLLISION_FLAG] <= write_collision_flag_nxt;
      csr_r[3:2] <= 2'h0;
      if (wr_csr) csr_r[1:0] <= i_wdata[1:0];
      // first byte after done was cleared stays until read; later ones dropped
      if (byte_done && !f_done && !rx_lock_r) rxbuf_r <= rx_byte;
      if (byte_done && f_done) rx_lock_r <= 1'b1;
      else if (rd_data) rx_lock_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // power modes and cpu read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_r <= 1'b0;
      halt_r <= 1'b0;
    end else if (wr_pwr) begin
      wait_r <= i_wdata[SEF_PW_WAIT];
      halt_r <= i_wdata[SEF_PW_HALT];
    end else begin
      if (o_wake_wait) wait_r <= 1'b0;
      if (o_wake_halt) halt_r <= 1'b0;
    end
  end

  // buffer is a plain register on i_mclk, so reads never collide
  wire [7:0] rd_mux = (i_addr == SEF_OFF_CTRL) ? ctrl_r :
                      (i_addr == SEF_OFF_CSR)  ? csr_r  :
                      (i_addr == SEF_OFF_DATA) ? rxbuf_r :
                      {6'h00, halt_r, wait_r};
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) rdata_r <= 8'h00;
    else if (i_rd) rdata_r <= rd_mux;
    else rdata_r <= 8'h00;
  end
  assign o_rdata = rdata_r;

  // one shared request; collision is not a source
  wire irq_src = irq_en && (f_done || f_mode_fault_flag || f_ovr);
  assign o_irq       = irq_src && !i_cpu_irq_mask;
  assign o_wake_wait = wait_r && o_irq;
  assign o_wake_halt = halt_r && irq_en && f_done && !i_cpu_irq_mask;

  // miso: msb of shift, driven only while selected slave and enabled
  logic miso_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) miso_r <= 1'b0;
    else if (!rx_on || fall) miso_r <= shift_r[7];
  end
  assign link.miso    = miso_r;
  assign link.miso_oe = rx_on;
endmodule

// ### sef_host.sv
// sef_host: far end, a simple controller that sends bytes to the device end
// assumes: software writes a byte to start; sclk made here by a divider of i_mclk
`timescale 1ns/100ps
module sef_host
  import sef_pkg::*;
#(
  parameter int HALF_DIV = SEF_HALF_DIV
)(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_addr,     // 0 data, 1 status, 2 select
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  sef_link_if.host        link
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SEF_H_IDLE = 2'b00, SEF_H_LOW = 2'b01, SEF_H_HIGH = 2'b11} sef_hst_t;
  sef_hst_t   st_r;
  logic [7:0] tx_r, rx_r, rdata_r;
  logic [3:0] bit_r;
  logic [7:0] div_r;
  logic       sel_r, done_r, sclk_r, mosi_r;
  logic [1:0] miso_s_r;
  wire tick = (div_r == 8'(HALF_DIV - 1));

  // miso through two flops before use; a released line reads high as with a pull-up
  wire miso_pin = link.miso_oe ? link.miso : 1'b1;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) miso_s_r <= 2'h0;
    else miso_s_r <= {miso_s_r[0], miso_pin};
  end

  // ---------------------------------------------------------------
  // byte engine: mode 0, msb first; select is software held so one slave
  // is chosen at a time and it can stay low across halt entry
  // miso is taken at the end of the high phase since the round trip through
  // both synchronisers is longer than one half period
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= SEF_H_IDLE;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      bit_r <= 4'h0;
      div_r <= 8'h00;
      sel_r <= 1'b0;
      done_r <= 1'b0;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      div_r <= (st_r == SEF_H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
      if (i_wr && i_addr == 2'h2) sel_r <= i_wdata[0];   // keep high while fault clears
      if (i_rd && i_addr == 2'h1) done_r <= 1'b0;
      unique case (st_r)
        SEF_H_IDLE: if (i_wr && i_addr == 2'h0) begin
          tx_r <= {i_wdata[6:0], 1'b0};
          mosi_r <= i_wdata[7];
          bit_r <= 4'h0;
          st_r <= SEF_H_LOW;
        end
        SEF_H_LOW: if (tick) begin
          sclk_r <= 1'b1;
          st_r <= SEF_H_HIGH;
        end
        SEF_H_HIGH: if (tick) begin
          sclk_r <= 1'b0;
          rx_r <= {rx_r[6:0], miso_s_r[1]};
          if (bit_r == 4'(SEF_BITS - 1)) begin
            done_r <= 1'b1;   // extra byte after halt wakeup is just another write
            st_r <= SEF_H_IDLE;
          end else begin
            mosi_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
            bit_r <= bit_r + 4'h1;
            st_r <= SEF_H_LOW;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) rdata_r <= 8'h00;
    else if (i_rd) rdata_r <= (i_addr == 2'h1) ? {done_r, 6'h00, st_r != SEF_H_IDLE} :
                              (i_addr == 2'h2) ? {7'h00, sel_r} : rx_r;
    else rdata_r <= 8'h00;
  end
  assign o_rdata    = rdata_r;
  assign link.sclk  = sclk_r;
  assign link.mosi  = mosi_r;
  assign link.sel_n = !sel_r;
endmodule

// ### sef_sva.sv
// sef_sva: link and cpu port checks of the device end
// assumes: instanced in the bench beside the link interface
`timescale 1ns/100ps
module sef_sva
  import sef_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  input wire logic       sclk,
  input wire logic       miso,
  input wire logic       miso_oe,
  input wire logic       sel_n,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_cpu_irq_mask,
  input wire logic       o_irq,
  input wire logic       o_wake_halt
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic ien_r;
  wire  rd_sr = i_rd && (i_addr == SEF_OFF_CSR);
  wire  evt   = o_rdata[SEF_SR_DONE] || o_rdata[SEF_SR_OVR] || o_rdata[SEF_SR_MODE_FAULT_FLAG];
  // shadow of the enable bit, the checker cannot see inside the device
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b)
      ien_r <= 1'b0;
    else if (i_wr && i_addr == SEF_OFF_CTRL)
      ien_r <= i_wdata[SEF_CR_IRQ_EN];
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_irq_mask; i_cpu_irq_mask |-> !o_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_irq_evt; (rd_sr && !i_cpu_irq_mask && ien_r) ##1 evt |-> $past(o_irq); endproperty
  a_irq_evt: assert property (p_irq_evt) else $error("flag set without irq");
  property p_write_collision_flag_quiet; rd_sr ##1 !evt |-> !$past(o_irq); endproperty
  a_write_collision_flag_quiet: assert property (p_write_collision_flag_quiet) else $error("irq without event");
  property p_halt_done; rd_sr ##1 !o_rdata[SEF_SR_DONE] |-> !$past(o_wake_halt); endproperty
  a_halt_done: assert property (p_halt_done) else $error("halt exit without done");
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_oe_sel; sel_n [*4] |-> !miso_oe; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("miso driven unselected");
  property p_miso_fall; $changed(miso) && !sel_n && !$past(sel_n) |-> !sclk; endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved with clock high");
  property p_ovr_clr;
    (sel_n [*4] ##0 rd_sr) ##[1:2] (rd_sr && sel_n) |=> !o_rdata[SEF_SR_OVR];
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept after read");
  c_irq: cover property (o_irq);
  c_wake: cover property (o_wake_halt);
  c_ovr: cover property (rd_sr ##1 o_rdata[SEF_SR_OVR]);
endmodule

// ### tb_sef.sv
// tb_sef: host and device joined over the link, device flags checked against a model
// assumes: host default divider, device register map of sef_pkg
`timescale 1ns/100ps
module tb_sef
  import sef_pkg::*;
;
  // ---------------------------------------------------------------
  // bench
  // ---------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  d_addr = 2'h0, h_addr = 2'h0;
  logic [7:0]  d_wd = 8'h00, h_wd = 8'h00, d_q, h_q, q;
  logic        d_wr = 1'b0, d_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0, mask = 1'b0;
  logic        irq, ww, wh, seen_w, seen_h;
  logic [15:0] rs = 16'hBDC8;
  int          errors = 0, n_tests = 0;
  int          m_done = 0, m_ovr = 0, m_write_collision_flag = 0, m_mode_fault_flag = 0, m_seen = 0, m_ien = 0;
  int          m_rx = 0, m_ctl = 0, m_sh = 0;
  sef_link_if lk ();
  sef_dev sef_dev_i (.i_mclk(mclk), .i_rst_b(rst_b), .i_addr(d_addr), .i_wdata(d_wd),
    .i_wr(d_wr), .i_rd(d_rd), .o_rdata(d_q), .i_cpu_irq_mask(mask), .o_irq(irq),
    .o_wake_wait(ww), .o_wake_halt(wh), .link(lk.dev));
  sef_host sef_host_i (.i_mclk(mclk), .i_rst_b(rst_b), .i_addr(h_addr), .i_wdata(h_wd),
    .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_q), .link(lk.host));
  sef_sva sef_sva_i (.i_mclk(mclk), .i_rst_b(rst_b), .sclk(lk.sclk), .miso(lk.miso),
    .miso_oe(lk.miso_oe), .sel_n(lk.sel_n), .i_addr(d_addr), .i_wdata(d_wd), .i_wr(d_wr),
    .i_rd(d_rd), .o_rdata(d_q), .i_cpu_irq_mask(mask), .o_irq(irq), .o_wake_halt(wh));
  always #(SEF_CLK_NS / 2) mclk = ~mclk;
  // wake levels are short, so latch them for the scenario to inspect
  always @(posedge mclk) begin
    if (ww === 1'b1)
      seen_w = 1'b1;
    if (wh === 1'b1)
      seen_h = 1'b1;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] xs();
    rs = rs ^ (rs << 7);
    rs = rs ^ (rs >> 9);
    rs = rs ^ (rs << 8);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one strobe cycle on either end; read data taken in the slot after
  task automatic bus(input bit h, input bit w, input logic [1:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge mclk);
    if (h) begin
      h_addr <= a;
      h_wd   <= d;
      h_wr   <= w;
      h_rd   <= !w;
    end else begin
      d_addr <= a;
      d_wd   <= d;
      d_wr   <= w;
      d_rd   <= !w;
    end
    @(posedge mclk);
    {h_wr, h_rd, d_wr, d_rd} <= 4'h0;
    #1 r = h ? h_q : d_q;
  endtask
  task automatic rcsr();
    #1 chk("irq", {7'h00, irq}, 8'(m_ien && !mask && (m_done || m_ovr || m_mode_fault_flag)));
    bus(0, 0, SEF_OFF_CSR, 8'h00, q);
    chk("status", q & 8'hF0, {m_done[0], m_write_collision_flag[0], m_ovr[0], m_mode_fault_flag[0], 4'h0});
    if (m_done || m_write_collision_flag || m_mode_fault_flag)
      m_seen = 1;
    m_ovr  = 0;
  endtask
  task automatic rdat();
    bus(0, 0, SEF_OFF_DATA, 8'h00, q);
    chk("rx byte", q, 8'(m_rx));
    if (m_seen) begin
      m_done = 0;
      m_write_collision_flag = 0;
    end
    m_seen = 0;
  endtask
  task automatic rctl();
    bus(0, 0, SEF_OFF_CTRL, 8'h00, q);
    chk("control", q, 8'(m_ctl));
  endtask
  // a refused write still sets the enable, only port and controller bits are held
  task automatic wctl(input logic [7:0] v);
    bus(0, 1, SEF_OFF_CTRL, v, q);
    if (m_mode_fault_flag && m_seen)
      m_mode_fault_flag = 0;
    m_ctl = m_mode_fault_flag ? (v & 8'hAF) : v;
    m_ien = v[SEF_CR_IRQ_EN];
    m_seen = 0;
  endtask
  task automatic send(input logic [7:0] b, input bit coll);
    int k;
    bus(1, 1, 2'h2, 8'h01, q);
    bus(1, 1, 2'h0, b, q);
    if (coll) begin
      for (k = 0; k < 100 && lk.sclk !== 1'b1; k++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      bus(0, 1, SEF_OFF_DATA, 8'hA5, q);
      m_write_collision_flag = 1;
    end
    for (k = 0; k < 200; k++) begin
      bus(1, 0, 2'h1, 8'h00, q);
      if (q[0] === 1'b0) break;
    end
    // the host gets back what the device shift register held, collision or not
    bus(1, 0, 2'h0, 8'h00, q);
    chk("host rx", q, 8'(m_sh));
    m_sh = b;
    repeat (6) @(posedge mclk);
    if (m_done)
      m_ovr = 1;
    else
      m_rx = b;
    m_done = 1;
    bus(1, 1, 2'h2, 8'h00, q);
    repeat (4) @(posedge mclk);
  endtask
  task automatic results();
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // watchdog: eight bytes of about a hundred cycles each need far less
  initial begin
    #(SEF_CLK_NS * 40000);
    errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // master enabled while the far end pulls select low
    wctl(8'hD0);
    rctl();
    bus(1, 1, 2'h2, 8'h01, q);
    repeat (6) @(posedge mclk);
    m_mode_fault_flag = 1;
    m_ctl  = m_ctl & 8'hAF;
    rctl();
    @(posedge mclk);
    mask <= 1'b1;
    @(posedge mclk);
    #1 chk("masked irq", {7'h00, irq}, 8'h00);
    mask <= 1'b0;
    bus(1, 1, 2'h2, 8'h00, q);
    wctl(8'hD0);
    rctl();
    rcsr();
    wctl(8'hC0);
    rcsr();
    rctl();
    // plain byte, then two bytes left uncleared
    send(8'(xs()), 0);
    rcsr();
    rdat();
    rcsr();
    send(8'(xs()), 0);
    send(8'(xs()), 0);
    rcsr();
    rcsr();
    rdat();
    rcsr();
    // collision mid transfer; a data write does not clear it
    send(8'(xs()), 1);
    rcsr();
    bus(0, 1, SEF_OFF_DATA, 8'h3C, q);
    // after the status read this write clears done and loads the shift register
    m_done = 0;
    m_sh   = 8'h3C;
    rcsr();
    rdat();
    rcsr();
    // wait then halt, each woken by a received byte
    for (int i = 0; i < 2; i++) begin
      seen_w = 1'b0;
      seen_h = 1'b0;
      bus(1, 1, 2'h2, 8'h01, q);
      bus(0, 1, SEF_OFF_PWR, 8'(1 << i), q);
      send(8'(xs()), 0);
      chk("wake", {7'h00, (i == 1) ? seen_h : seen_w}, 8'h01);
      rcsr();
      rdat();
      send(8'(xs()), 0);
      rcsr();
      rdat();
    end
    results();
  end
endmodule
